/* pkg/sio_pkg.sv */
// ****************************************************************
// shared constants of the host bus and interrupt port
// ****************************************************************
package sio_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int NSRC = 6; // a rx, a tx, a ext, b rx, b tx, b ext

    // register offsets on the select lines
    localparam logic [4:0] OFS_IRQ_CTRL = 5'h01;
    localparam logic [4:0] OFS_PENDING = 5'h02;
    localparam logic [4:0] OFS_VECTOR = 5'h0C;

    // field positions
    localparam int CTRL_EN_LSB = 0; // six source enables
    localparam int CTRL_SAV_BIT = 7; // vector carries status
    localparam int VEC_CODE_LSB = 1; // three-bit routine code

    // reset values
    localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
    localparam logic [7:0] RST_VECTOR = 8'h0F;
    localparam logic [7:0] UNMAPPED_RD = 8'hFF;

    // routine codes per source, index 0 is highest priority
    localparam logic [2:0] CODE_A_RX = 3'h6;
    localparam logic [2:0] CODE_A_TX = 3'h4;
    localparam logic [2:0] CODE_A_EXT = 3'h5;
    localparam logic [2:0] CODE_B_RX = 3'h2;
    localparam logic [2:0] CODE_B_TX = 3'h0;
    localparam logic [2:0] CODE_B_EXT = 3'h1;

    // host gives up an unanswered vector cycle after this many cycles
    localparam int VEC_TIMEOUT_CYC = 64;
endpackage : sio_pkg

/* pkg/sio_bus_if.sv */
`timescale 1ns/100ps
// ****************************************************************
// parallel host bus with tri-state resolution
// ****************************************************************
interface sio_bus_if;
    logic cs_n;
    logic vector_ack_n;
    logic rw;
    logic [4:0] register_select_lines;
    logic [7:0] host_dout;
    logic host_doe_n;
    logic [7:0] dev_dout;
    logic dev_doe_n;
    logic [7:0] host_data_lines;
    logic ack_out;
    logic ack_oe_n;
    logic transfer_ack_n;
    logic irq_oe_n;
    logic irq_n;
    logic chain_enable_in;
    logic chain_enable_out;

    // released lines float high through pull-ups
    assign host_data_lines = !dev_doe_n ? dev_dout :
                             (!host_doe_n ? host_dout : 8'hFF);
    assign transfer_ack_n = ack_oe_n ? 1'b1 : ack_out;
    assign irq_n = irq_oe_n; // open drain, only ever pulls low

    modport dev (
        input cs_n, vector_ack_n, rw, register_select_lines,
        input host_data_lines, chain_enable_in,
        output dev_dout, dev_doe_n, ack_out, ack_oe_n, irq_oe_n,
        output chain_enable_out
    );
    modport host (
        output cs_n, vector_ack_n, rw, register_select_lines,
        output host_dout, host_doe_n, chain_enable_in,
        input host_data_lines, transfer_ack_n, irq_n
    );
endinterface : sio_bus_if

/* hw/sio_sync.sv */
`timescale 1ns/100ps
// ****************************************************************
// two-flop synchroniser for pin inputs
// ****************************************************************
module sio_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // sync reset, active low
    input wire logic [W-1:0] async_i, // pin levels
    output logic [W-1:0] sync_o // levels safe to use
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_q <= INIT;
            sync_o <= INIT;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : sio_sync

/* hw/sio_dev.sv */
`timescale 1ns/100ps
module sio_dev #(
    parameter int NSRC = sio_pkg::NSRC
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // sync reset, active low
    sio_bus_if.dev bus, // host bus pins
    input wire logic [NSRC-1:0] event_i, // source events, pulses
    output logic [NSRC-1:0] pending_o, // latched requests
    output logic [7:0] irq_ctrl_o // control register copy
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_SET, ST_RD_ACK, ST_WR_ACK,
        ST_VEC_WAIT, ST_VEC_SET, ST_VEC_ACK, ST_ACK_HI
    } sio_dst_t;
    typedef enum logic [1:0] {K_RD, K_WR, K_VEC} sio_kind_t;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [16:0] pin_s;
    logic cs_s, vector_ack_n_s, rw_s, chain_s;
    logic [4:0] addr_s;
    logic [7:0] din_s;

    // strobes idle high, so reset them high to avoid a false edge
    sio_sync #(.W(17), .INIT(17'h18000)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i({bus.cs_n, bus.vector_ack_n, bus.rw,
                  bus.chain_enable_in, bus.register_select_lines,
                  bus.host_data_lines}),
        .sync_o(pin_s)
    );
    assign {cs_s, vector_ack_n_s, rw_s, chain_s, addr_s, din_s} = pin_s;

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    // routine code for a source index
    function automatic logic [2:0] src_code(input logic [2:0] idx);
        unique case (idx)
            3'h0: src_code = sio_pkg::CODE_A_RX;
            3'h1: src_code = sio_pkg::CODE_A_TX;
            3'h2: src_code = sio_pkg::CODE_A_EXT;
            3'h3: src_code = sio_pkg::CODE_B_RX;
            3'h4: src_code = sio_pkg::CODE_B_TX;
            default: src_code = sio_pkg::CODE_B_EXT;
        endcase
    endfunction : src_code

    // lowest set index wins: channel a rx down to channel b ext
    function automatic logic [2:0] top_src(input logic [NSRC-1:0] p);
        top_src = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                top_src = 3'(i);
            end
        end
    endfunction : top_src

    // ****************************************************************
    // state and registers
    // ****************************************************************
    sio_dst_t state_q, state_d;
    sio_kind_t kind_q, kind_d;
    logic cs_prev_q, vector_ack_n_prev_q;
    logic [7:0] ctrl_q, vec_q, dout_q, dout_d;
    logic [NSRC-1:0] pend_q, pend_d, clr_mask;
    logic [2:0] idx_q, idx_d;
    logic dout_oe_n_q, ack_q, ack_oe_n_q, irq_oe_n_q, chain_out_q;

    wire cs_fall = cs_prev_q & ~cs_s;
    wire vector_ack_n_fall = vector_ack_n_prev_q & ~vector_ack_n_s;
    wire any_pend = |pend_q;
    wire wr_take = (state_q == ST_IDLE) && cs_fall && !rw_s;
    wire hit_ctrl = addr_s == sio_pkg::OFS_IRQ_CTRL;
    wire hit_vec = addr_s == sio_pkg::OFS_VECTOR;
    wire hit_pend = addr_s == sio_pkg::OFS_PENDING;
    wire sav = ctrl_q[sio_pkg::CTRL_SAV_BIT];
    wire [NSRC-1:0] src_en = ctrl_q[sio_pkg::CTRL_EN_LSB +: NSRC];

    // read mux; anything unmapped reads as all ones
    wire [7:0] rd_val = hit_ctrl ? ctrl_q :
                        hit_vec ? vec_q :
                        hit_pend ? 8'(pend_q) :
                        sio_pkg::UNMAPPED_RD;

    // status option replaces three vector bits with the code
    wire [2:0] code = src_code(idx_q);
    wire [7:0] vec_out = sav ? {vec_q[7:4], code, vec_q[0]} : vec_q;

    // ****************************************************************
    // cycle sequencer
    // ****************************************************************
    // ST_RD_SET, ST_VEC_SET and ST_ACK_HI each last one fixed cycle; the other steps wait on a strobe or chain level
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        idx_d = idx_q;
        unique case (state_q)
            ST_IDLE: begin
                if (cs_fall) begin
                    kind_d = rw_s ? K_RD : K_WR;
                    state_d = rw_s ? ST_RD_SET : ST_WR_ACK;
                end else if (vector_ack_n_fall && any_pend) begin
                    kind_d = K_VEC;
                    idx_d = top_src(pend_q);
                    state_d = ST_VEC_WAIT;
                end
            end
            ST_RD_SET: state_d = ST_RD_ACK;
            ST_RD_ACK, ST_WR_ACK, ST_VEC_ACK: begin
                if ((kind_q == K_VEC) ? vector_ack_n_s : cs_s) begin
                    state_d = ST_ACK_HI;
                end
            end
            ST_VEC_WAIT: begin
                if (vector_ack_n_s) begin
                    state_d = ST_IDLE; // chain passed it over
                end else if (!chain_s) begin
                    state_d = ST_VEC_SET;
                end
            end
            ST_VEC_SET: state_d = ST_VEC_ACK;
            ST_ACK_HI: state_d = ST_IDLE;
        endcase
    end

    // data word latched as a cycle starts driving
    assign dout_d = (state_q == ST_IDLE && state_d == ST_RD_SET) ?
                    rd_val :
                    (state_d == ST_VEC_SET && state_q != ST_VEC_SET) ?
                    vec_out : dout_q;

    // request cleared as its vector goes out; a new event wins
    assign clr_mask = (state_d == ST_VEC_SET && state_q != ST_VEC_SET) ?
                      NSRC'(1) << idx_q : '0;
    assign pend_d = (pend_q & ~clr_mask) | (event_i & src_en);

    // ****************************************************************
    // pin drivers, all from flops of the next state
    // ****************************************************************
    wire ack_drv = state_d inside {ST_RD_ACK, ST_WR_ACK, ST_VEC_ACK,
                                   ST_ACK_HI};
    wire data_drv = state_d inside {ST_RD_SET, ST_RD_ACK, ST_VEC_SET,
                                    ST_VEC_ACK} ||
                    (state_d == ST_ACK_HI && kind_q != K_WR);
    wire in_vec = (state_d != ST_IDLE) && (kind_d == K_VEC);
    wire irq_drv = (|pend_d) && !in_vec;

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            kind_q <= K_RD;
            idx_q <= 3'h0;
            cs_prev_q <= 1'b1;
            vector_ack_n_prev_q <= 1'b1;
            pend_q <= '0;
            dout_q <= 8'h00;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            idx_q <= idx_d;
            cs_prev_q <= cs_s;
            vector_ack_n_prev_q <= vector_ack_n_s;
            pend_q <= pend_d;
            dout_q <= dout_d;
        end
    end

    // software registers; pending register is read only
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_q <= sio_pkg::RST_IRQ_CTRL;
            vec_q <= sio_pkg::RST_VECTOR;
        end else if (wr_take) begin
            if (hit_ctrl) begin
                ctrl_q <= din_s;
            end
            if (hit_vec) begin
                vec_q <= din_s;
            end // other addresses store nothing
        end
    end

    // output enables are low while driving
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            dout_oe_n_q <= 1'b1;
            ack_q <= 1'b1;
            ack_oe_n_q <= 1'b1;
            irq_oe_n_q <= 1'b1;
            chain_out_q <= 1'b1;
        end else begin
            dout_oe_n_q <= !data_drv;
            ack_q <= (state_d == ST_ACK_HI);
            ack_oe_n_q <= !ack_drv;
            irq_oe_n_q <= !irq_drv;
            chain_out_q <= ((|pend_d) || in_vec) ? 1'b1 : chain_s;
        end
    end

    assign bus.dev_dout = dout_q;
    assign bus.dev_doe_n = dout_oe_n_q;
    assign bus.ack_out = ack_q;
    assign bus.ack_oe_n = ack_oe_n_q;
    assign bus.irq_oe_n = irq_oe_n_q;
    assign bus.chain_enable_out = chain_out_q;
    assign pending_o = pend_q;
    assign irq_ctrl_o = ctrl_q;
endmodule : sio_dev

/* hw/sio_host.sv */
`timescale 1ns/100ps
// ****************************************************************
// bus master end: register cycles and vector fetches
// ****************************************************************
module sio_host #(
    parameter int TMO = sio_pkg::VEC_TIMEOUT_CYC
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // sync reset, active low
    sio_bus_if.host bus, // host bus pins
    input wire logic req_i, // register cycle request, pulse
    input wire logic req_rd_i, // 1 read, 0 write
    input wire logic [4:0] req_addr_i, // register select
    input wire logic [7:0] req_wdata_i, // write data
    input wire logic vreq_i, // vector fetch request, pulse
    output logic busy_o, // cycle in progress
    output logic done_o, // cycle finished, pulse
    output logic timeout_o, // vector fetch unanswered, pulse
    output logic [7:0] rdata_o, // read data or vector
    output logic irq_o // device requests service
);
    typedef enum logic [2:0] {
        H_IDLE, H_SETUP, H_CS, H_CS_REL, H_VECTOR_ACK_N, H_VECTOR_ACK_N_REL
    } sio_hst_t;

    logic [9:0] pin_s;
    logic ack_s, irq_s;
    logic [7:0] din_s;

    // acknowledge and request idle high
    sio_sync #(.W(10), .INIT(10'h300)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i({bus.transfer_ack_n, bus.irq_n, bus.host_data_lines}),
        .sync_o(pin_s)
    );
    assign {ack_s, irq_s, din_s} = pin_s;

    sio_hst_t state_q, state_d;
    logic [$clog2(TMO+1)-1:0] cnt_q;
    logic rd_q, doe_n_q, done_q, tmo_q, irq_q, busy_q;
    logic [4:0] addr_q;
    logic [7:0] wdata_q, rdata_q;

    wire tmo_hit = (cnt_q == ($clog2(TMO+1))'(TMO));

    // one sequencer owns both strobes, so they never overlap
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            H_IDLE: begin
                if (req_i) begin
                    state_d = H_SETUP; // address settles first
                end else if (vreq_i) begin
                    state_d = H_VECTOR_ACK_N;
                end
            end
            H_SETUP: state_d = H_CS;
            H_CS: if (!ack_s) state_d = H_CS_REL;
            H_CS_REL: if (ack_s) state_d = H_IDLE;
            H_VECTOR_ACK_N: begin
                if (!ack_s) begin
                    state_d = H_VECTOR_ACK_N_REL;
                end else if (tmo_hit) begin
                    state_d = H_IDLE; // nobody answered
                end
            end
            H_VECTOR_ACK_N_REL: if (ack_s) state_d = H_IDLE;
        endcase
    end

    wire finish = (state_d == H_IDLE) && (state_q != H_IDLE);
    wire take = (state_q inside {H_CS, H_VECTOR_ACK_N}) && !ack_s;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= H_IDLE;
            cnt_q <= '0;
            rd_q <= 1'b1;
            addr_q <= 5'h00;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            doe_n_q <= 1'b1;
            done_q <= 1'b0;
            tmo_q <= 1'b0;
            irq_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_q == H_VECTOR_ACK_N) ? cnt_q + 1'b1 : '0;
            if (state_q == H_IDLE && req_i) begin
                rd_q <= req_rd_i;
                addr_q <= req_addr_i;
                wdata_q <= req_wdata_i;
            end
            if (take) begin
                rdata_q <= din_s;
            end
            // data driven only across a write cycle
            doe_n_q <= !(state_d inside {H_SETUP, H_CS, H_CS_REL} &&
                         !((state_q == H_IDLE) ? req_rd_i : rd_q));
            done_q <= finish;
            tmo_q <= finish && (state_q == H_VECTOR_ACK_N) && ack_s;
            irq_q <= !irq_s;
            busy_q <= (state_d != H_IDLE);
        end
    end

    // strobes registered from the next state
    logic cs_n_q, vector_ack_n_n_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cs_n_q <= 1'b1;
            vector_ack_n_n_q <= 1'b1;
        end else begin
            cs_n_q <= !(state_d == H_CS);
            vector_ack_n_n_q <= !(state_d == H_VECTOR_ACK_N);
        end
    end

    assign bus.cs_n = cs_n_q;
    assign bus.vector_ack_n = vector_ack_n_n_q;
    assign bus.rw = rd_q;
    assign bus.register_select_lines = addr_q;
    assign bus.host_dout = wdata_q;
    assign bus.host_doe_n = doe_n_q;
    assign bus.chain_enable_in = 1'b0;
    assign busy_o = busy_q; // flop, so the pin never glitches
    assign done_o = done_q;
    assign timeout_o = tmo_q;
    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
endmodule : sio_host

/* verif/sio_bus_checker.sv */
`timescale 1ns/100ps
// ********
// wire checks on the joined host bus
// ********
module sio_bus_checker (
    input wire logic clk_sys_i, // clock
    input wire logic rst_n_i, // reset, low
    input wire logic cs_n, // select strobe
    input wire logic vector_ack_n, // vector strobe
    input wire logic rw, // 1 read
    input wire logic dev_doe_n, // device data oe
    input wire logic ack_out, // ack level
    input wire logic ack_oe_n, // ack oe
    input wire logic transfer_ack_n, // resolved ack
    input wire logic irq_oe_n, // request pull
    input wire logic irq_n, // resolved request
    input wire logic chain_enable_in, // chain in
    input wire logic chain_enable_out // chain out
);
    // one clock; checks rest while reset is low
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // reset releases lines, so it must not be masked by reset
    reset_release_a: assert property (disable iff (1'b0)
        !rst_n_i ##1 !rst_n_i |-> dev_doe_n && ack_oe_n && irq_oe_n)
        else $error("lines not released in reset");
    read_data_first_a: assert property (
        $fell(transfer_ack_n) && !cs_n && rw
        |-> !dev_doe_n && !$past(dev_doe_n))
        else $error("read ack before data");
    write_no_drive_a: assert property (
        !cs_n && !rw && !transfer_ack_n |-> dev_doe_n)
        else $error("device drives data in write");
    ack_stands_a: assert property (
        !transfer_ack_n && !(cs_n && vector_ack_n) |=> !transfer_ack_n)
        else $error("ack dropped while strobe low");
    ack_high_first_a: assert property (
        $rose(ack_oe_n) |-> $past(ack_out) && !$past(ack_oe_n))
        else $error("ack released without high drive");
    data_held_a: assert property (
        !dev_doe_n && !ack_oe_n |=> !dev_doe_n || ack_oe_n)
        else $error("data released before ack");
    vec_data_first_a: assert property (
        $fell(transfer_ack_n) && !vector_ack_n
        |-> !dev_doe_n && !$past(dev_doe_n) && irq_oe_n)
        else $error("vector ack order wrong");
    irq_off_vec_a: assert property (
        !transfer_ack_n && !vector_ack_n |-> irq_n)
        else $error("request held in vector cycle");
    strobe_excl_a: assert property (
        cs_n || vector_ack_n)
        else $error("both strobes low");
    chain_block_a: assert property (
        !irq_n && !$past(irq_n) |-> chain_enable_out)
        else $error("chain open while requesting");
    // idle long enough: chain output tracks chain input
    chain_follow_a: assert property (
        (irq_n && vector_ack_n)[*8] ##1 irq_n[*2]
        |-> $past(chain_enable_out, 2) == $past(chain_enable_in, 2))
        else $error("idle chain output not following");
    // direction settles a cycle before select falls
    select_setup_a: assert property (
        $fell(cs_n) |-> $stable(rw))
        else $error("direction moved as select fell");
    // stand-alone master keeps the chain input low
    chain_tied_a: assert property (
        !chain_enable_in)
        else $error("chain input not held low");
endmodule : sio_bus_checker

/* verif/serial_ctrl_host_bus_irq_port_tb.sv */
`timescale 1ns/100ps
// ********
// bench: host and device ends, plus a device on a driven bus
// ********
module serial_ctrl_host_bus_irq_port_tb;
    localparam logic [4:0] CTL = sio_pkg::OFS_IRQ_CTRL;
    localparam logic [4:0] VEC = sio_pkg::OFS_VECTOR;
    logic clk_sys_i;
    logic rst_n_i;
    logic req_i, req_rd_i, vreq_i, busy_o, done_o, timeout_o, irq_o;
    logic [4:0] req_addr_i;
    logic [7:0] req_wdata_i, rdata_o, irq_ctrl_o;
    logic [5:0] event_i, event2_i, pending_o, pending2_o;
    int miscompares;
    int tests_run;
    sio_bus_if bus ();
    sio_bus_if bus2 ();

    // short timeout keeps the no-request case quick
    sio_host #(.TMO(20)) sio_host_inst (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .bus(bus), .req_i(req_i), .req_rd_i(req_rd_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .vreq_i(vreq_i), .busy_o(busy_o), .done_o(done_o),
        .timeout_o(timeout_o), .rdata_o(rdata_o), .irq_o(irq_o));
    sio_dev sio_dev_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .bus(bus), .event_i(event_i), .pending_o(pending_o),
        .irq_ctrl_o(irq_ctrl_o));
    // second device: bench drives its bus, setting the chain input high or low
    sio_dev sio_dev_chain_inst (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .bus(bus2), .event_i(event2_i),
        .pending_o(pending2_o), .irq_ctrl_o());
    sio_bus_checker sio_bus_checker_inst (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .cs_n(bus.cs_n),
        .vector_ack_n(bus.vector_ack_n), .rw(bus.rw),
        .dev_doe_n(bus.dev_doe_n), .ack_out(bus.ack_out),
        .ack_oe_n(bus.ack_oe_n), .transfer_ack_n(bus.transfer_ack_n),
        .irq_oe_n(bus.irq_oe_n), .irq_n(bus.irq_n),
        .chain_enable_in(bus.chain_enable_in),
        .chain_enable_out(bus.chain_enable_out));

    // 50 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // ********
    // shared tasks
    // ********
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    task automatic give_up(input string what);
        miscompares++;
        $display("wrong value %s: wait bound used up", what);
        tally_and_finish();
    endtask : give_up

    // one register or vector cycle through the host end
    task automatic host_cycle(input logic vec, input logic rd,
            input logic [4:0] a, input logic [7:0] d,
            output logic to_seen, output logic ack_seen);
        int n;
        @(negedge clk_sys_i);
        req_i = !vec;
        vreq_i = vec;
        req_rd_i = rd;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_sys_i);
        req_i = 1'b0;
        vreq_i = 1'b0;
        check("busy", {7'h00, busy_o}, 8'h01);
        ack_seen = 1'b0;
        for (n = 0; n < 200 && done_o !== 1'b1; n++) begin
            if (bus.transfer_ack_n === 1'b0) ack_seen = 1'b1;
            @(negedge clk_sys_i);
        end
        if (n == 200) give_up("host cycle");
        to_seen = timeout_o;
    endtask : host_cycle

    task automatic reg_io(input logic rd, input logic [4:0] a,
                          input logic [7:0] d);
        logic t, k;
        host_cycle(1'b0, rd, a, d, t, k);
    endtask : reg_io

    task automatic wait_irq(input logic v);
        int n;
        for (n = 0; n < 30 && irq_o !== v; n++) @(negedge clk_sys_i);
        if (n == 30) give_up("host request flag");
    endtask : wait_irq

    // waits for {chain out, ack oe, ack line} on the driven bus
    task automatic wait2(input logic [2:0] v);
        int n;
        for (n = 0; n < 40; n++) begin
            if ({bus2.chain_enable_out, bus2.ack_oe_n,
                 bus2.transfer_ack_n} === v) break;
            @(negedge clk_sys_i);
        end
        if (n == 40) give_up("driven bus state");
    endtask : wait2

    task automatic pulse(input logic [5:0] e1, input logic [5:0] e2);
        @(negedge clk_sys_i);
        event_i = e1;
        event2_i = e2;
        @(negedge clk_sys_i);
        event_i = 6'h00;
        event2_i = 6'h00;
    endtask : pulse

    // ********
    // scenarios
    // ********
    task automatic t_reset();
        check("pending", {2'b00, pending_o}, 8'h00);
        check("ack line", {7'h00, bus.transfer_ack_n}, 8'h01);
        check("data lines", bus.host_data_lines, 8'hFF);
        check("request", {7'h00, bus.irq_n}, 8'h01);
        reg_io(1'b1, CTL, 8'h00);
        check("ctrl reset", rdata_o, sio_pkg::RST_IRQ_CTRL);
        reg_io(1'b1, VEC, 8'h00);
        check("vector reset", rdata_o, sio_pkg::RST_VECTOR);
        $display("reset test done");
    endtask : t_reset

    task automatic t_regs();
        reg_io(1'b0, CTL, 8'h15);
        check("ctrl copy", irq_ctrl_o, 8'h15);
        reg_io(1'b0, VEC, 8'hA0);
        reg_io(1'b0, 5'h1F, 8'h5A);
        check("ctrl kept", irq_ctrl_o, 8'h15);
        reg_io(1'b1, VEC, 8'h00);
        check("vector kept", rdata_o, 8'hA0);
        reg_io(1'b1, 5'h1F, 8'h00);
        check("unmapped read", rdata_o, 8'hFF);
        reg_io(1'b0, sio_pkg::OFS_PENDING, 8'h3F);
        reg_io(1'b1, sio_pkg::OFS_PENDING, 8'h00);
        check("pending read only", rdata_o, 8'h00);
        $display("register test done");
    endtask : t_regs

    task automatic t_vec();
        logic t, k;
        logic [5:0] left;
        logic [2:0] codes [6] = '{sio_pkg::CODE_A_RX, sio_pkg::CODE_A_TX,
            sio_pkg::CODE_A_EXT, sio_pkg::CODE_B_RX, sio_pkg::CODE_B_TX,
            sio_pkg::CODE_B_EXT};
        // only enabled sources latch
        pulse(6'h3F, 6'h00);
        wait_irq(1'b1);
        check("gated pending", {2'b00, pending_o}, 8'h15);
        check("chain held", {7'h00, bus.chain_enable_out}, 8'h01);
        host_cycle(1'b1, 1'b0, 5'h00, 8'h00, t, k);
        check("plain vector", rdata_o, 8'hA0);
        check("top cleared", {2'b00, pending_o}, 8'h14);
        reg_io(1'b0, CTL, 8'hBF);
        pulse(6'h3F, 6'h00);
        left = 6'h3F;
        for (int i = 0; i < 6; i++) begin
            wait_irq(1'b1);
            host_cycle(1'b1, 1'b0, 5'h00, 8'h00, t, k);
            left[i] = 1'b0;
            check("coded vector", rdata_o, {4'hA, codes[i], 1'b0});
            check("pending order", {2'b00, pending_o}, {2'b00, left});
        end
        wait_irq(1'b0);
        $display("vector test done");
    endtask : t_vec

    task automatic t_nopend();
        logic t, k;
        host_cycle(1'b1, 1'b0, 5'h00, 8'h00, t, k);
        check("ignored timeout", {7'h00, t}, 8'h01);
        check("ignored ack", {7'h00, k}, 8'h00);
        $display("no request test done");
    endtask : t_nopend

    task automatic t_chain();
        logic bad;
        bad = 1'b0;
        wait2(3'b111);
        bus2.chain_enable_in = 1'b0;
        wait2(3'b011);
        // enable all sources on the driven device
        bus2.rw = 1'b0;
        bus2.register_select_lines = CTL;
        bus2.host_dout = 8'h3F;
        bus2.host_doe_n = 1'b0;
        bus2.cs_n = 1'b0;
        wait2(3'b000);
        bus2.cs_n = 1'b1;
        wait2(3'b011);
        bus2.host_doe_n = 1'b1;
        pulse(6'h00, 6'h02);
        wait2(3'b111);
        // upstream device busy: nothing may answer
        bus2.chain_enable_in = 1'b1;
        bus2.vector_ack_n = 1'b0;
        repeat (12) begin
            @(negedge clk_sys_i);
            if (bus2.ack_oe_n !== 1'b1 ||
                bus2.dev_doe_n !== 1'b1) bad = 1'b1;
        end
        check("withheld", {7'h00, bad}, 8'h00);
        bus2.chain_enable_in = 1'b0;
        wait2(3'b100);
        check("chain vector", bus2.host_data_lines,
              sio_pkg::RST_VECTOR);
        check("chain cleared", {2'b00, pending2_o}, 8'h00);
        bus2.vector_ack_n = 1'b1;
        wait2(3'b011);
        check("released data", bus2.host_data_lines, 8'hFF);
        $display("chain test done");
    endtask : t_chain

    // main sequence
    initial begin
        miscompares = 0;
        tests_run = 0;
        rst_n_i = 1'b0;
        {req_i, vreq_i, req_rd_i} = 3'b000;
        req_addr_i = 5'h00;
        req_wdata_i = 8'h00;
        event_i = 6'h00;
        event2_i = 6'h00;
        {bus2.cs_n, bus2.vector_ack_n, bus2.rw} = 3'b111;
        bus2.register_select_lines = 5'h00;
        bus2.host_dout = 8'h00;
        bus2.host_doe_n = 1'b1;
        bus2.chain_enable_in = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        t_reset();
        t_regs();
        t_vec();
        t_nopend();
        t_chain();
        tally_and_finish();
    end
endmodule : serial_ctrl_host_bus_irq_port_tb
